// [design/sbtc_sync3.sv]
// Three-stage synchroniser for bus lines, with agreement filter.
// Assumes lines idle high; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sbtc_sync3 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // Lines
  input  wire logic [W-1:0] line_i,
  output logic      [W-1:0] line_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sbtc_filt_t;

  sbtc_filt_t st_r;
  sbtc_filt_t st_nxt;
  logic [W-1:0] agree_q;

  // Only s2 and s3 are compared; s1 feeds s2 alone
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree_q[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s3[i] : st_r.q[i];
  end

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = line_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q  = agree_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign line_o = st_r.q;
endmodule // sbtc_sync3
`default_nettype wire

// [design/sbtc_top.sv]
// Serial bus timing and configuration: SCL generation, SDA setup/hold,
// timeout support and the configuration register.
// Assumes timer overflow pulses and control inputs are on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Master bit rate is about the selected overflow rate over three.
// R2 - Master SCL high lasts two overflow periods, low lasts one.
// R3 - SCL high or low never shorter than one overflow period.
// R4 - SDA held stable for setup before rise and hold after fall.
// R5 - Extended timing: setup eleven clocks, hold twelve clocks.
// R6 - Normal timing: hold three clocks, setup one clock plus stall delay.
// R7 - Software picks extension so setup and hold reach 250 and 300 ns.
// R8 - Software clears extension when SCL exceeds 100 kHz.
// R9 - Low timeout timer reloads while SCL high, counts while SCL low.
// R10 - Software sets timeout timer to 25 ms and resets interface on overflow.
// R11 - Bus free once both lines high for more than ten ticks.
// R12 - Free timeout acts as STOP: sets stop flag, raises interrupt.
// R13 - Software should enable free timeout and keep a clock source running.
// R14 - Select bits pick timer0, timer1, timer2 high or timer2 low overflow.
// R15 - Enable bit lets the interface respond to all bus events.
// R16 - Inhibit blocks slave events from the next START onward; while disabled it applies at once.
// R17 - Busy set during a transfer, cleared by STOP or free timeout.
// R18 - Configuration resets to zero: disabled, timeouts off, timer0.
module sbtc_top (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Configuration register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Clock source overflows
  input  wire logic       t0_ovf_i,
  input  wire logic       t1_ovf_i,
  input  wire logic       t2h_ovf_i,
  input  wire logic       t2l_ovf_i,
  // Control from the transfer engine
  input  wire logic       master_req_i,
  input  wire logic       sda_tx_i,
  input  wire logic       stall_i,
  // Bus pins, open drain
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Status and timer control
  output logic            slave_en_o,
  output logic            bus_free_o,
  output logic            stop_flag_set_o,
  output logic            intr_set_o,
  output logic            t3_reload_o,
  output logic            t3_run_o
);
  typedef struct packed {
    sbtc_pkg::sbtc_mst_t mst;
    logic [7:0]          cfg;
    logic [7:0]          rdata;
    logic [4:0]          cnt;
    logic [1:0]          ph;
    logic                scl_drv;
    logic                sda_drv;
    logic                busy;
    logic                slv_en;
    logic [3:0]          fcnt;
    logic                fdone;
    logic                free_p;
    logic                t3_rel;
    logic                t3_run;
    logic                scl_p;
    logic                sda_p;
  } sbtc_st_t;

  sbtc_st_t   st_r;
  sbtc_st_t   st_nxt;
  logic [1:0] lines_q;
  logic       scl_q;
  logic       sda_q;
  logic       tick_q;
  logic       en_q;
  logic       ext_q;
  logic       start_q;
  logic       stop_q;
  logic [4:0] hold_q;
  logic [4:0] rel_q;

  sbtc_sync3 #(.W(2)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .line_i     ({scl_i, sda_i}),
    .line_o     (lines_q)
  );

  assign scl_q   = lines_q[1];
  assign sda_q   = lines_q[0];
  assign en_q    = st_r.cfg[sbtc_pkg::BIT_ENABLE];
  assign ext_q   = st_r.cfg[sbtc_pkg::BIT_HOLD_EXT];
  assign start_q = scl_q && st_r.scl_p && st_r.sda_p && !sda_q;
  assign stop_q  = scl_q && st_r.scl_p && !st_r.sda_p && sda_q;
  assign hold_q  = ext_q ? sbtc_pkg::HOLD_EXT : sbtc_pkg::HOLD_STD; // R5 R6
  assign rel_q   = ext_q ? 5'(sbtc_pkg::HOLD_EXT + sbtc_pkg::SETUP_EXT)
                         : 5'(sbtc_pkg::HOLD_STD + sbtc_pkg::SETUP_STD); // R4

  // Clock source mux
  always_comb begin
    unique case (st_r.cfg[sbtc_pkg::BIT_CS_HI:sbtc_pkg::BIT_CS_LO]) // R14
      sbtc_pkg::CS_TIMER0:    tick_q = t0_ovf_i;
      sbtc_pkg::CS_TIMER1:    tick_q = t1_ovf_i;
      sbtc_pkg::CS_TIMER2_HI: tick_q = t2h_ovf_i;
      sbtc_pkg::CS_TIMER2_LO: tick_q = t2l_ovf_i;
    endcase
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.scl_p  = scl_q;
    st_nxt.sda_p  = sda_q;
    st_nxt.free_p = 1'b0;

    // Register port; busy bit is read only
    if (sfr_wr_i && sfr_addr_i == sbtc_pkg::CFG_ADDR) begin
      st_nxt.cfg = sfr_wdata_i & sbtc_pkg::CFG_WR_MASK;
    end
    if (sfr_rd_i && sfr_addr_i == sbtc_pkg::CFG_ADDR) begin
      st_nxt.rdata = st_r.cfg;
      st_nxt.rdata[sbtc_pkg::BIT_BUSY] = st_r.busy;
    end

    // Low timeout timer control
    st_nxt.t3_rel = st_r.cfg[sbtc_pkg::BIT_LOW_TO_EN] && scl_q; // R9
    st_nxt.t3_run = st_r.cfg[sbtc_pkg::BIT_LOW_TO_EN] && !scl_q; // R9

    // Free timeout: more than ten ticks with both lines high
    if (!(en_q && st_r.cfg[sbtc_pkg::BIT_FREE_EN] && scl_q && sda_q)) begin
      st_nxt.fcnt  = 4'h0;
      st_nxt.fdone = 1'b0;
    end else if (tick_q && !st_r.fdone) begin
      if (st_r.fcnt == sbtc_pkg::FREE_TICKS) begin // R11
        st_nxt.free_p = 1'b1; // R12
        st_nxt.fdone  = 1'b1;
      end else begin
        st_nxt.fcnt = st_r.fcnt + 4'h1;
      end
    end

    // Busy and slave inhibit; inhibit latched at START, and followed directly while disabled
    if (!en_q) begin
      st_nxt.busy   = 1'b0;
      st_nxt.slv_en = !st_r.cfg[sbtc_pkg::BIT_INHIBIT];
    end else if (start_q) begin
      st_nxt.busy   = 1'b1; // R17
      st_nxt.slv_en = !st_r.cfg[sbtc_pkg::BIT_INHIBIT]; // R16
    end else if (stop_q || st_nxt.free_p) begin
      st_nxt.busy   = 1'b0; // R17
    end
    if (st_r.mst != sbtc_pkg::MST_IDLE) begin
      st_nxt.busy = 1'b1;
    end

    // Master SCL generation, phase edges aligned to ticks
    if (st_r.cnt != sbtc_pkg::CNT_MAX) begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end
    unique case (st_r.mst)
      sbtc_pkg::MST_IDLE: begin
        st_nxt.scl_drv = 1'b0;
        st_nxt.sda_drv = 1'b0;
        if (en_q && master_req_i && tick_q) begin // R15
          st_nxt.mst     = sbtc_pkg::MST_LOW;
          st_nxt.scl_drv = 1'b1;
          st_nxt.cnt     = 5'h00;
          st_nxt.ph      = 2'h0;
        end
      end
      sbtc_pkg::MST_LOW: begin
        // SDA may only change once hold has elapsed
        if (st_r.cnt == hold_q) begin
          st_nxt.sda_drv = !sda_tx_i; // R4
        end
        if (tick_q && st_r.ph != sbtc_pkg::LOW_TICKS) begin
          st_nxt.ph = st_r.ph + 2'h1; // R3
        end
        // A stall stretches low; the setup then includes the stall
        if (st_r.ph == sbtc_pkg::LOW_TICKS && st_r.cnt >= rel_q && !stall_i) begin // R2 R4 R6
          st_nxt.mst     = sbtc_pkg::MST_REL;
          st_nxt.scl_drv = 1'b0;
        end
      end
      sbtc_pkg::MST_REL: begin
        // Waits here while another device stretches the clock
        if (!master_req_i) begin
          st_nxt.mst = sbtc_pkg::MST_IDLE;
        end else if (scl_q) begin
          st_nxt.mst = sbtc_pkg::MST_HIGH;
          st_nxt.ph  = 2'h0;
        end
      end
      sbtc_pkg::MST_HIGH: begin
        if (!master_req_i) begin
          st_nxt.mst = sbtc_pkg::MST_IDLE;
        end else if (!scl_q) begin
          // Another master pulled low off-tick; wrap to zero on next tick so a whole period still counts
          st_nxt.mst     = sbtc_pkg::MST_LOW;
          st_nxt.scl_drv = 1'b1;
          st_nxt.cnt     = 5'h00;
          st_nxt.ph      = 2'h3; // R3
        end else if (tick_q) begin
          if (st_r.ph == sbtc_pkg::HIGH_TICKS - 2'h1) begin // R1 R2 R3
            st_nxt.mst     = sbtc_pkg::MST_LOW;
            st_nxt.scl_drv = 1'b1;
            st_nxt.cnt     = 5'h00;
            st_nxt.ph      = 2'h0;
          end else begin
            st_nxt.ph = st_r.ph + 2'h1;
          end
        end
      end
    endcase
    if (!en_q) begin
      st_nxt.mst     = sbtc_pkg::MST_IDLE;
      st_nxt.scl_drv = 1'b0;
      st_nxt.sda_drv = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r        <= '0;
      st_r.cfg    <= sbtc_pkg::CFG_RESET; // R18
      st_r.slv_en <= 1'b1;
      st_r.scl_p  <= 1'b1;
      st_r.sda_p  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o     = st_r.rdata;
  assign scl_o           = 1'b0 & st_r.scl_p;
  assign sda_o           = 1'b0 & st_r.sda_p;
  assign scl_oe_o        = st_r.scl_drv;
  assign sda_oe_o        = st_r.sda_drv;
  assign slave_en_o      = st_r.slv_en;
  assign bus_free_o      = st_r.free_p;
  assign stop_flag_set_o = st_r.free_p;
  assign intr_set_o      = st_r.free_p;
  assign t3_reload_o     = st_r.t3_rel;
  assign t3_run_o        = st_r.t3_run;

  // Checks
  property p_low_full;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(scl_oe_o) && en_q |-> $past(st_r.ph) == sbtc_pkg::LOW_TICKS;
  endproperty
  a_low_full: assert property (p_low_full) else $error("SCL low released early"); // R3
  property p_high_two;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(scl_oe_o) && $past(st_r.mst) == sbtc_pkg::MST_HIGH && $past(scl_q)
      |-> $past(st_r.ph) == 2'h1 && $past(tick_q);
  endproperty
  a_high_two: assert property (p_high_two) else $error("SCL high phase wrong length"); // R2
  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.mst == sbtc_pkg::MST_LOW && $changed(sda_oe_o) |-> $past(st_r.cnt) == $past(hold_q);
  endproperty
  a_hold: assert property (p_hold) else $error("SDA changed inside hold time"); // R4
  property p_setup_ext;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(scl_oe_o) && ext_q && en_q |-> $past(sda_oe_o, 11) == sda_oe_o;
  endproperty
  a_setup_ext: assert property (p_setup_ext) else $error("SDA setup under eleven clocks"); // R5
  property p_t3;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.cfg[sbtc_pkg::BIT_LOW_TO_EN] && scl_q |=> t3_reload_o && !t3_run_o;
  endproperty
  a_t3: assert property (p_t3) else $error("Timeout timer not reloaded"); // R9
  property p_free;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus_free_o |-> $past(st_r.fcnt) == sbtc_pkg::FREE_TICKS && stop_flag_set_o && intr_set_o;
  endproperty
  a_free: assert property (p_free) else $error("Free timeout mistimed"); // R11 R12
  property p_busy;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus_free_o && $past(st_r.mst) == sbtc_pkg::MST_IDLE |-> !st_r.busy;
  endproperty
  a_busy: assert property (p_busy) else $error("Busy not cleared by free timeout"); // R17
  property p_inh;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    en_q && start_q |=> slave_en_o == !$past(st_r.cfg[sbtc_pkg::BIT_INHIBIT]);
  endproperty
  a_inh: assert property (p_inh) else $error("Slave inhibit not taken at START"); // R16
  property p_dis;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !en_q |=> !scl_oe_o && !sda_oe_o;
  endproperty
  a_dis: assert property (p_dis) else $error("Disabled interface drives bus"); // R15
  property p_stall;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    en_q && st_r.mst == sbtc_pkg::MST_LOW && stall_i |=> scl_oe_o;
  endproperty
  a_stall: assert property (p_stall) else $error("SCL released during stall"); // R6
endmodule // sbtc_top
`default_nettype wire

// [include/sbtc_pkg.sv]
// Constants and types for the serial bus timing and configuration block.
// Assumes one system clock; all counts are in system clocks or clock-source ticks.
package sbtc_pkg;

  // Configuration register location, reset and bit positions
  localparam logic [7:0] CFG_ADDR      = 8'hC1;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] CFG_WR_MASK   = 8'hDF;
  localparam int         BIT_ENABLE    = 7;
  localparam int         BIT_INHIBIT   = 6;
  localparam int         BIT_BUSY      = 5;
  localparam int         BIT_HOLD_EXT  = 4;
  localparam int         BIT_LOW_TO_EN = 3;
  localparam int         BIT_FREE_EN   = 2;
  localparam int         BIT_CS_HI     = 1;
  localparam int         BIT_CS_LO     = 0;

  // Clock source codes
  localparam logic [1:0] CS_TIMER0     = 2'h0;
  localparam logic [1:0] CS_TIMER1     = 2'h1;
  localparam logic [1:0] CS_TIMER2_HI  = 2'h2;
  localparam logic [1:0] CS_TIMER2_LO  = 2'h3;

  // SDA timing in system clocks
  localparam logic [4:0] HOLD_STD      = 5'h03;
  localparam logic [4:0] SETUP_STD     = 5'h01;
  localparam logic [4:0] HOLD_EXT      = 5'h0C;
  localparam logic [4:0] SETUP_EXT     = 5'h0B;
  localparam logic [4:0] CNT_MAX       = 5'h1F;

  // SCL phases and free timeout in clock-source ticks
  localparam logic [1:0] LOW_TICKS     = 2'h1;
  localparam logic [1:0] HIGH_TICKS    = 2'h2;
  localparam logic [3:0] FREE_TICKS    = 4'hA;

  typedef enum logic [1:0] {MST_IDLE, MST_LOW, MST_REL, MST_HIGH} sbtc_mst_t;

endpackage

// [verification/sbtc_far_end.sv]
// Far-side bus device: stretches SCL low after each fall, pulls lines on command.
// Assumes open-drain wires resolved by the bench; never drives a line high.
`timescale 1ns/1ps
`default_nettype none
module sbtc_far_end (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Bus and commands
  input  wire logic       scl_i,
  input  wire logic [7:0] stretch_i,
  input  wire logic       scl_low_i,
  input  wire logic       sda_low_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o
);
  logic [7:0] cnt_r;
  logic       scl_q_r;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r   <= 8'h00;
      scl_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      if (scl_q_r && !scl_i) begin
        cnt_r <= stretch_i;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  // Low extension only, as a slow slave would
  assign scl_pull_o = scl_low_i || (cnt_r != 8'h00);
  assign sda_pull_o = sda_low_i;
endmodule // sbtc_far_end
`default_nettype wire

// [verification/smbus_timing_and_config_bench.sv]
// Self-checking bench: register port, free timeout, low timeout, SCL timing.
// Assumes the far-side model and open-drain wires resolved here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module smbus_timing_and_config_bench;
  typedef struct {string nm; logic [7:0] v;} sbtc_note_t;
  sbtc_note_t q[$];
  logic       core_clk_i = 1'b0;
  logic       rst_n_i    = 1'b0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic [7:0] cfg_v      = 8'h00;
  logic [7:0] stretch    = 8'h00;
  logic [3:0] ovf        = 4'h0;
  logic [15:0] lfsr      = 16'h6596;
  logic       wr = 1'b0, rd = 1'b0, rd_pend = 1'b0, req = 1'b0, tx = 1'b1, stall = 1'b0;
  logic       scl_low = 1'b0, sda_low = 1'b0;
  logic [7:0] rdata;
  logic       scl_oe, sda_oe, slv_en, bfree, stop_s, intr_s, t3_rl, t3_run, scl_pull, sda_pull;
  logic       scl_lv, sda_lv;
  int         n_errors = 0, total_checks = 0, n_ticks = 0, gen_per = 0, gen_sel = 0, gcnt = 0;
  wire        scl = !(scl_oe || scl_pull);
  wire        sda = !(sda_oe || sda_pull);

  always #12.5 core_clk_i = ~core_clk_i;

  sbtc_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .t0_ovf_i(ovf[0]), .t1_ovf_i(ovf[1]),
    .t2h_ovf_i(ovf[2]), .t2l_ovf_i(ovf[3]), .master_req_i(req), .sda_tx_i(tx), .stall_i(stall),
    .scl_i(scl), .scl_o(scl_lv), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_lv), .sda_oe_o(sda_oe),
    .slave_en_o(slv_en), .bus_free_o(bfree), .stop_flag_set_o(stop_s), .intr_set_o(intr_s),
    .t3_reload_o(t3_rl), .t3_run_o(t3_run));

  sbtc_far_end far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .stretch_i(stretch),
    .scl_low_i(scl_low), .sda_low_i(sda_low), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

  // Tick source: one overflow line pulses every gen_per cycles
  always @(posedge core_clk_i) begin
    gcnt = (gen_per > 0) ? gcnt + 1 : 0;
    if (gcnt >= gen_per && gen_per > 0) begin
      gcnt = 0;
      n_ticks++;
    end
    ovf <= #2 (gcnt == 0 && gen_per > 0) ? (4'h1 << gen_sel) : 4'h0;
  end

  // Result watcher; an unexpected pulse pops an empty note and fails
  always @(negedge core_clk_i) begin : watch
    sbtc_note_t n;
    if (rd_pend) begin
      n = q.pop_front();
      `CHK(n.nm, n.v, rdata)
    end
    rd_pend = rd && (addr === sbtc_pkg::CFG_ADDR);
    if (bfree === 1'b1) begin
      n = q.pop_front();
      `CHK(n.nm, n.v, n_ticks[7:0])
      n = q.pop_front();
      `CHK(n.nm, n.v, {6'h00, stop_s, intr_s})
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic cyc(int n = 1);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc();
    wr = 1'b0;
    // Idle edge so a following write never re-raises the strobe in the same step
    cyc();
  endtask

  task automatic rd_reg(logic [7:0] e);
    q.push_back('{"cfg", e});
    addr = sbtc_pkg::CFG_ADDR;
    rd = 1'b1;
    cyc();
    rd = 1'b0;
  endtask

  task automatic wait_oe(logic lv);
    for (int k = 0; k < 400 && scl_oe !== lv; k++) cyc();
    `CHK("scl_oe_wait", lv, scl_oe)
  endtask

  // Each bit: hold point, low length and ticks, high length and ticks
  task automatic run_bits(int nb, int hold, int min_lo, bit tk);
    int t0;
    int len;
    logic old;
    wait_oe(1'b0);
    wait_oe(1'b1);
    for (int b = 0; b < nb; b++) begin
      t0 = n_ticks;
      old = sda_oe;
      cfg_v = rnd();
      tx = cfg_v[0];
      cyc(hold);
      `CHK("sda_hold", old, sda_oe)
      cyc();
      `CHK("sda_bit", !tx, sda_oe)
      len = hold + 1;
      for (int k = 0; k < 400 && scl_oe === 1'b1; k++) begin
        cyc();
        len++;
      end
      `CHK("low_len", 1'b1, len >= min_lo)
      if (tk) `CHK("low_ticks", 1, n_ticks - t0)
      t0 = n_ticks;
      len = 0;
      for (int k = 0; k < 400 && scl_oe !== 1'b1; k++) begin
        cyc();
        len += int'(scl === 1'b1);
      end
      `CHK("high_len", 1'b1, len >= gen_per)
      if (tk) `CHK("high_ticks", 2, n_ticks - t0)
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    cyc(3);
    rst_n_i = 1'b1;
    cyc(2);
    `CHK("scl_oe", 1'b0, scl_oe)
    `CHK("slave_en", 1'b1, slv_en)
    `CHK("drive_lv", 2'h0, {scl_lv, sda_lv})
    rd_reg(sbtc_pkg::CFG_RESET);
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h40);
    cyc();
    `CHK("slave_en_inh", 1'b0, slv_en)
    repeat (4) begin
      cfg_v = rnd();
      wr_reg(sbtc_pkg::CFG_ADDR, cfg_v);
      wr_reg(8'hC2, ~cfg_v);
      rd_reg(cfg_v & sbtc_pkg::CFG_WR_MASK);
    end
    for (int cs = 0; cs < 4; cs++) begin
      wr_reg(sbtc_pkg::CFG_ADDR, 8'h84 | 8'(cs));
      gen_sel = (cs + 1) % 4;
      gen_per = 4;
      cyc(60);
      gen_per = 0;
      sda_low = 1'b1;
      cyc(4);
      sda_low = 1'b0;
      cyc(8);
      gen_sel = cs;
      n_ticks = 0;
      q.push_back('{"free_ticks", 8'h0B});
      q.push_back('{"free_flags", 8'h03});
      gen_per = 4;
      cyc(90);
      `CHK("free_left", 0, q.size())
    end
    gen_per = 0;
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h88);
    cyc(6);
    `CHK("t3_reload", 1'b1, t3_rl)
    scl_low = 1'b1;
    cyc(6);
    `CHK("t3_run", 1'b1, t3_run)
    `CHK("t3_reload_lo", 1'b0, t3_rl)
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h08);
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h88);
    cyc(2);
    `CHK("t3_run_again", 1'b1, t3_run)
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h80);
    cyc(2);
    `CHK("t3_run_off", 1'b0, t3_run)
    scl_low = 1'b0;
    gen_sel = 1;
    gen_per = 20;
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h81);
    req = 1'b1;
    run_bits(3, int'(sbtc_pkg::HOLD_STD), 20, 1'b1);
    stall = 1'b1;
    cyc(40);
    `CHK("stall_low", 1'b1, scl_oe)
    stall = 1'b0;
    cyc();
    `CHK("stall_end", 1'b0, scl_oe)
    stretch = 8'h32;
    run_bits(2, int'(sbtc_pkg::HOLD_STD), 20, 1'b0);
    stretch = 8'h00;
    gen_per = 4;
    wr_reg(sbtc_pkg::CFG_ADDR, 8'h91);
    run_bits(3, int'(sbtc_pkg::HOLD_EXT), int'(sbtc_pkg::HOLD_EXT + sbtc_pkg::SETUP_EXT), 1'b0);
    req = 1'b0;
    cyc(50);
    summarize();
  end

  initial begin
    #300000;
    n_errors++;
    summarize();
  end
endmodule // smbus_timing_and_config_bench
`default_nettype wire
